//--- core/mgmt_pkg.sv
package mgmt_pkg;

    localparam int          PREAMBLE_BITS     = 32;
    localparam int          MAX_SLAVES        = 32;
    localparam int          ADDR_W            = 5;
    localparam int          DATA_W            = 16;
    localparam int          TA_BITS           = 2;
    localparam logic [1:0]  SOF_PATTERN       = 2'h1;
    localparam logic [1:0]  OP_READ           = 2'h2;
    localparam logic [1:0]  OP_WRITE          = 2'h1;
    localparam logic [1:0]  TA_WRITE          = 2'h2;
    localparam logic [1:0]  TA_READ_HOST      = 2'h0;
    localparam logic        TA_READ_DRIVE     = 1'b0;
    localparam logic        IDLE_LEVEL        = 1'b1;

    localparam logic [4:0]  REG_EXT_CTRL      = 5'h11;
    localparam int          POWER_MODE_LSB    = 11;
    localparam int          POWER_MODE_W      = 4;
    localparam logic [3:0]  PM_STANDBY        = 4'hC;
    localparam logic [15:0] PM_MASK           = 16'h7800;

    localparam int          FRAME_BITS        = 64;
    localparam int          READ_HOST_BITS    = 46;
    localparam int          DATA_FIRST_BIT    = 48;
    localparam logic [31:0] PREAMBLE_WORD     = 32'hFFFFFFFF;

    localparam int          MDC_MAX_FREQ_KHZ  = 2500;
    localparam int          MDC_MIN_PERIOD_NS = 400;
    localparam int          MCLK_PERIOD_NS    = 5;
    localparam int          MDC_HALF_CYCLES   =
        (MDC_MIN_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    function automatic logic [3:0] pm_field(input logic [15:0] d);
        pm_field = d[POWER_MODE_LSB +: POWER_MODE_W];
    endfunction : pm_field

endpackage : mgmt_pkg

//--- core/mgmt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mgmt_if;
    logic mdc;
    logic mdio_host_out;
    logic mdio_host_oe;
    logic mdio_phy_out;
    logic mdio_phy_oe;
    logic mdio;

    // Pull-up gives a one when nobody drives
    assign mdio = mdio_host_oe ? mdio_host_out :
                  (mdio_phy_oe ? mdio_phy_out : mgmt_pkg::IDLE_LEVEL);

    modport host (output mdc, output mdio_host_out, output mdio_host_oe, input mdio);
    modport phy  (input mdc, input mdio, output mdio_phy_out, output mdio_phy_oe);
endinterface : mgmt_if
`default_nettype wire

//--- core/mgmt_phy_slave.sv
// Overview of operation
// - Host keeps management clock period at least 400ns.
// - Host drives writes; phy drives read data.
// - In sleep only power mode reads, standby writes.
// - One host, up to 32 addressed phys.
// - Fields: preamble, start, opcode, addresses, turnaround, data.
// - Frame opens with 32 ones on data line.
// - Start pattern after preamble is 01.
// - Opcode 10 reads, 01 writes.
// - Five bit phy address, compared to own.
// - Five bit register address, MSB first.
// - Turnaround: read Z then 0, write 10.
// - Data field holds exactly sixteen bits.
// - Idle line undriven, pulled to one.
// - Data line sampled on clock rising edge.
// - Extended control register sits at address 0x11.
`timescale 1ns/1ps
`default_nettype none
module mgmt_phy_slave #(
    parameter int PREAMBLE_BITS = mgmt_pkg::PREAMBLE_BITS
) (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    mgmt_if.phy              bus,
    input  wire logic [4:0]  own_bus_address_field_in,
    input  wire logic        sleep_in,
    input  wire logic [15:0] rd_data_in,
    output logic             rd_req_out,
    output logic [4:0]       reg_addr_out,
    output logic [15:0]      wr_data_out,
    output logic             wr_strobe_out
);

    typedef enum logic [6:0] {
        ST_PRE  = 7'h01,
        ST_SOF  = 7'h02,
        ST_OP   = 7'h04,
        ST_PHY  = 7'h08,
        ST_REG  = 7'h10,
        ST_TA   = 7'h20,
        ST_DATA = 7'h40
    } slave_state_t;

    if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > mgmt_pkg::PREAMBLE_BITS) begin : g_chk
        $error("PREAMBLE_BITS out of range");
    end

    localparam logic [5:0] PRE_FULL = 6'(PREAMBLE_BITS);

    slave_state_t state_q;
    logic [5:0]   cnt_q;
    logic         mdc_s1_q;
    logic         mdc_s2_q;
    logic         mdc_s3_q;
    logic         mdio_s1_q;
    logic         mdio_s2_q;
    logic [1:0]   op_q;
    logic [4:0]   phy_q;
    logic [4:0]   reg_q;
    logic [15:0]  rx_q;
    logic [15:0]  tx_q;
    logic         is_read_q;
    logic         selected_q;
    logic         respond_q;
    logic         out_q;
    logic         oe_q;
    logic         rd_req_q;
    logic         wr_strobe_q;
    logic [4:0]   reg_addr_q;
    logic [15:0]  wr_data_q;

    logic         rise;
    logic         bit_in;
    logic [1:0]   op_now;
    logic [4:0]   reg_now;
    logic [15:0]  wdata_now;
    logic         addr_match;
    logic         read_allowed;
    logic         write_allowed;

    // Both pins resynchronised equally, so data and clock stay aligned
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            mdc_s1_q  <= 1'b0;
            mdc_s2_q  <= 1'b0;
            mdc_s3_q  <= 1'b0;
            mdio_s1_q <= 1'b1;
            mdio_s2_q <= 1'b1;
        end else begin
            mdc_s1_q  <= bus.mdc;
            mdc_s2_q  <= mdc_s1_q;
            mdc_s3_q  <= mdc_s2_q;
            mdio_s1_q <= bus.mdio;
            mdio_s2_q <= mdio_s1_q;
        end
    end

    assign rise          = mdc_s2_q & ~mdc_s3_q;
    assign bit_in        = mdio_s2_q;
    assign op_now        = {op_q[0], bit_in};
    assign reg_now       = {reg_q[3:0], bit_in};
    assign wdata_now     = {rx_q[14:0], bit_in};
    assign addr_match    = (phy_q == own_bus_address_field_in);
    assign read_allowed  = !sleep_in || (reg_now == mgmt_pkg::REG_EXT_CTRL);
    assign write_allowed = !sleep_in ||
                           ((reg_q == mgmt_pkg::REG_EXT_CTRL) &&
                            (mgmt_pkg::pm_field(wdata_now) == mgmt_pkg::PM_STANDBY));

    // Frame sequencer; a broken start or opcode field drops back to preamble hunting
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_q <= ST_PRE;
            cnt_q   <= 6'h00;
        end else if (rise) begin
            case (state_q)
                ST_PRE: begin
                    if (bit_in) begin
                        if (cnt_q != PRE_FULL) begin
                            cnt_q <= cnt_q + 6'h01;
                        end
                    end else if (cnt_q == PRE_FULL) begin
                        state_q <= ST_SOF;
                        cnt_q   <= 6'h00;
                    end else begin
                        cnt_q <= 6'h00;
                    end
                end
                ST_SOF: begin
                    state_q <= (bit_in == mgmt_pkg::SOF_PATTERN[0]) ? ST_OP : ST_PRE;
                    cnt_q   <= 6'h00;
                end
                ST_OP: begin
                    if (cnt_q == 6'h01) begin
                        cnt_q   <= 6'h00;
                        state_q <= (op_now == mgmt_pkg::OP_READ ||
                                    op_now == mgmt_pkg::OP_WRITE) ? ST_PHY : ST_PRE;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ST_PHY: begin
                    if (cnt_q == 6'(mgmt_pkg::ADDR_W - 1)) begin
                        state_q <= ST_REG;
                        cnt_q   <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ST_REG: begin
                    if (cnt_q == 6'(mgmt_pkg::ADDR_W - 1)) begin
                        state_q <= ST_TA;
                        cnt_q   <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ST_TA: begin
                    if (cnt_q == 6'(mgmt_pkg::TA_BITS - 1)) begin
                        state_q <= ST_DATA;
                        cnt_q   <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ST_DATA: begin
                    if (cnt_q == 6'(mgmt_pkg::DATA_W - 1)) begin
                        state_q <= ST_PRE;
                        cnt_q   <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                default: begin
                    state_q <= ST_PRE;
                    cnt_q   <= 6'h00;
                end
            endcase
        end
    end

    // Field capture, MSB first
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            op_q       <= 2'h0;
            phy_q      <= 5'h00;
            reg_q      <= 5'h00;
            rx_q       <= 16'h0000;
            is_read_q  <= 1'b0;
            selected_q <= 1'b0;
            respond_q  <= 1'b0;
        end else if (rise) begin
            case (state_q)
                ST_OP: begin
                    op_q      <= op_now;
                    is_read_q <= (op_now == mgmt_pkg::OP_READ);
                end
                ST_PHY: phy_q <= {phy_q[3:0], bit_in};
                ST_REG: begin
                    reg_q <= reg_now;
                    if (cnt_q == 6'(mgmt_pkg::ADDR_W - 1)) begin
                        selected_q <= addr_match;
                        respond_q  <= addr_match && is_read_q && read_allowed;
                    end
                end
                ST_DATA: begin
                    rx_q <= wdata_now;
                    if (cnt_q == 6'(mgmt_pkg::DATA_W - 1)) begin
                        selected_q <= 1'b0;
                        respond_q  <= 1'b0;
                    end
                end
                default: begin
                    selected_q <= selected_q;
                end
            endcase
        end
    end

    // Read drive: take the line after the Z bit, release after the last data bit
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            out_q <= mgmt_pkg::IDLE_LEVEL;
            oe_q  <= 1'b0;
            tx_q  <= 16'h0000;
        end else if (rise && respond_q) begin
            if (state_q == ST_TA && cnt_q == 6'h00) begin
                oe_q  <= 1'b1;
                out_q <= mgmt_pkg::TA_READ_DRIVE;
                // In sleep only the power mode field carries valid state
                tx_q  <= sleep_in ? (rd_data_in & mgmt_pkg::PM_MASK) : rd_data_in;
            end else if (state_q == ST_TA ||
                         (state_q == ST_DATA && cnt_q != 6'(mgmt_pkg::DATA_W - 1))) begin
                out_q <= tx_q[15];
                tx_q  <= {tx_q[14:0], 1'b0};
            end else if (state_q == ST_DATA) begin
                oe_q  <= 1'b0;
                out_q <= mgmt_pkg::IDLE_LEVEL;
            end
        end else if (!respond_q) begin
            oe_q  <= 1'b0;
            out_q <= mgmt_pkg::IDLE_LEVEL;
        end
    end

    // User side requests
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rd_req_q    <= 1'b0;
            wr_strobe_q <= 1'b0;
            reg_addr_q  <= 5'h00;
            wr_data_q   <= 16'h0000;
        end else begin
            rd_req_q    <= 1'b0;
            wr_strobe_q <= 1'b0;
            if (rise && state_q == ST_REG && cnt_q == 6'(mgmt_pkg::ADDR_W - 1) && addr_match) begin
                reg_addr_q <= reg_now;
                rd_req_q   <= is_read_q && read_allowed;
            end
            if (rise && state_q == ST_DATA && cnt_q == 6'(mgmt_pkg::DATA_W - 1) &&
                selected_q && !is_read_q && write_allowed) begin
                wr_data_q   <= wdata_now;
                wr_strobe_q <= 1'b1;
            end
        end
    end

    assign bus.mdio_phy_out = out_q;
    assign bus.mdio_phy_oe  = oe_q;
    assign rd_req_out       = rd_req_q;
    assign reg_addr_out     = reg_addr_q;
    assign wr_data_out      = wr_data_q;
    assign wr_strobe_out    = wr_strobe_q;

endmodule : mgmt_phy_slave
`default_nettype wire

//--- core/mgmt_host_master.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_host_master #(
    parameter int MDC_HALF = mgmt_pkg::MDC_HALF_CYCLES
) (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    mgmt_if.host             bus,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [4:0]  cmd_phy_addr_in,
    input  wire logic [4:0]  cmd_reg_addr_in,
    input  wire logic [15:0] cmd_wdata_in,
    output logic             cmd_ready_out,
    output logic             rsp_valid_out,
    output logic [15:0]      rsp_rdata_out
);

    typedef enum logic [1:0] {
        H_IDLE = 2'h1,
        H_RUN  = 2'h2
    } host_state_t;

    // Clock may not run faster than the shortest allowed period
    if (MDC_HALF < 1 || MDC_HALF > 65535 ||
        2 * MDC_HALF * mgmt_pkg::MCLK_PERIOD_NS < mgmt_pkg::MDC_MIN_PERIOD_NS) begin : g_chk
        $error("MDC_HALF too small or too large");
    end

    localparam logic [15:0] HALF_LAST = 16'(MDC_HALF - 1);

    host_state_t state_q;
    logic [15:0] half_q;
    logic [6:0]  bit_q;
    logic [63:0] frame_q;
    logic        write_q;
    logic        mdc_q;
    logic        out_q;
    logic        oe_q;
    logic        ready_q;
    logic        rsp_q;
    logic [15:0] rdata_q;
    logic        mdio_s1_q;
    logic        mdio_s2_q;
    logic        tick;
    logic [6:0]  bit_next;

    assign tick     = (half_q == HALF_LAST);
    assign bit_next = bit_q + 7'h01;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            mdio_s1_q <= 1'b1;
            mdio_s2_q <= 1'b1;
        end else begin
            mdio_s1_q <= bus.mdio;
            mdio_s2_q <= mdio_s1_q;
        end
    end

    // Bits change on the falling edge so the phy samples mid-bit on the rising one
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_q <= H_IDLE;
            half_q  <= 16'h0000;
            bit_q   <= 7'h00;
            frame_q <= 64'h0;
            write_q <= 1'b0;
            mdc_q   <= 1'b0;
            out_q   <= mgmt_pkg::IDLE_LEVEL;
            oe_q    <= 1'b0;
            ready_q <= 1'b0;
            rsp_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            rsp_q <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    mdc_q   <= 1'b0;
                    ready_q <= 1'b1;
                    if (cmd_valid_in && ready_q) begin
                        ready_q <= 1'b0;
                        write_q <= cmd_write_in;
                        frame_q <= {mgmt_pkg::PREAMBLE_WORD, mgmt_pkg::SOF_PATTERN,
                                    cmd_write_in ? mgmt_pkg::OP_WRITE : mgmt_pkg::OP_READ,
                                    cmd_phy_addr_in, cmd_reg_addr_in,
                                    cmd_write_in ? mgmt_pkg::TA_WRITE : mgmt_pkg::TA_READ_HOST,
                                    cmd_write_in ? cmd_wdata_in : 16'h0000};
                        bit_q   <= 7'h00;
                        half_q  <= 16'h0000;
                        out_q   <= mgmt_pkg::PREAMBLE_WORD[31];
                        oe_q    <= 1'b1;
                        state_q <= H_RUN;
                    end
                end
                H_RUN: begin
                    half_q <= tick ? 16'h0000 : half_q + 16'h0001;
                    if (tick && !mdc_q) begin
                        mdc_q <= 1'b1;
                        if (!write_q && bit_q >= 7'(mgmt_pkg::DATA_FIRST_BIT)) begin
                            rdata_q <= {rdata_q[14:0], mdio_s2_q};
                        end
                    end else if (tick) begin
                        mdc_q <= 1'b0;
                        if (bit_q == 7'(mgmt_pkg::FRAME_BITS - 1)) begin
                            oe_q    <= 1'b0;
                            out_q   <= mgmt_pkg::IDLE_LEVEL;
                            rsp_q   <= 1'b1;
                            state_q <= H_IDLE;
                        end else begin
                            bit_q   <= bit_next;
                            out_q   <= frame_q[62];
                            frame_q <= {frame_q[62:0], 1'b0};
                            // Release for the Z turnaround bit of a read
                            oe_q    <= write_q ||
                                       (bit_next < 7'(mgmt_pkg::READ_HOST_BITS));
                        end
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                    oe_q    <= 1'b0;
                end
            endcase
        end
    end

    assign bus.mdc           = mdc_q;
    assign bus.mdio_host_out = out_q;
    assign bus.mdio_host_oe  = oe_q;
    assign cmd_ready_out     = ready_q;
    assign rsp_valid_out     = rsp_q;
    assign rsp_rdata_out     = rdata_q;

endmodule : mgmt_host_master
`default_nettype wire

//--- bench/mgmt_props.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_props #(
    parameter int MDC_HALF = mgmt_pkg::MDC_HALF_CYCLES
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic mdc,
    input wire logic mdio_host_out,
    input wire logic mdio_host_oe,
    input wire logic mdio_phy_out,
    input wire logic mdio_phy_oe,
    input wire logic mdio
);
    logic [6:0]  cnt_q;
    logic [11:0] hcnt_q;
    logic        last_q;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);

    // Clock rises since the host took the line; the host takes it once per frame
    always_ff @(posedge mclk_in) begin
        if (srst_in || $rose(mdio_host_oe)) begin
            cnt_q <= 7'h00;
        end else if ($rose(mdc) && cnt_q != 7'h7F) begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    always_ff @(posedge mclk_in) begin
        if ($rose(mdc)) begin
            last_q <= mdio;
        end
    end

    // Saturates so a long idle gap never wraps into a short count
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            hcnt_q <= 12'hFFF;
        end else if ($changed(mdc)) begin
            hcnt_q <= 12'h000;
        end else if (hcnt_q != 12'hFFF) begin
            hcnt_q <= hcnt_q + 12'h001;
        end
    end

    a_no_bus_fight: assert property (
        !(mdio_host_oe && mdio_phy_oe)) else $error("both ends drive the data line");
    a_mdc_half_period: assert property (
        $changed(mdc) |-> hcnt_q >= MDC_HALF - 1) else $error("clock phase too short");
    a_preamble_ones: assert property (
        $rose(mdc) && cnt_q < 7'd32 |-> mdio) else $error("preamble bit not one");
    a_start_pattern: assert property (
        $rose(mdc) && (cnt_q == 7'd32 || cnt_q == 7'd33) |-> mdio == cnt_q[0])
        else $error("bad start pattern");
    a_opcode_legal: assert property (
        $rose(mdc) && cnt_q == 7'd35 |-> mdio != last_q) else $error("illegal opcode");
    a_host_bit_stable: assert property (
        $changed(mdio_host_out) |-> $fell(mdc) || !mdio_host_oe)
        else $error("host data moved away from a falling clock");
    a_host_release: assert property (
        $fell(mdio_host_oe) |-> cnt_q == 7'd46 || cnt_q == 7'd64)
        else $error("host released the line at a wrong bit");
    a_phy_turnaround: assert property (
        $rose(mdio_phy_oe) |-> cnt_q == 7'd47 && mdio_phy_out == mgmt_pkg::TA_READ_DRIVE)
        else $error("device turnaround wrong");
    a_phy_release: assert property (
        $fell(mdio_phy_oe) |-> cnt_q == 7'd64) else $error("device released at a wrong bit");
    // Checked only once the clock is back low, since a read leaves it high after release
    a_idle_stopped: assert property (
        cnt_q == 7'd64 && !mdc && !$rose(mdio_host_oe) |->
        !mdio_host_oe && !mdio_phy_oe && mdio)
        else $error("line not idle after frame");
endmodule : mgmt_props
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int HALF = 40;
    typedef struct packed {
        logic [4:0]  own;
        logic        wr;
        logic [4:0]  pa;
        logic [4:0]  ra;
        logic [15:0] wd;
        logic [15:0] rd;
        logic        slp;
        logic [15:0] exp;
        logic [1:0]  stb;
        logic [1:0]  req;
    } row_t;
    // A req of 2 means the pulse is left unchecked
    row_t rows [11] = '{
        '{5'h13, 1'h1, 5'h13, 5'h00, 16'hA5C3, 16'h0000, 1'h0, 16'h0000, 2'h1, 2'h2},
        '{5'h13, 1'h0, 5'h13, 5'h1F, 16'h0000, 16'h8001, 1'h0, 16'h8001, 2'h0, 2'h1},
        '{5'h13, 1'h0, 5'h0C, 5'h1F, 16'h0000, 16'h8001, 1'h0, 16'hFFFF, 2'h0, 2'h0},
        '{5'h13, 1'h1, 5'h0C, 5'h04, 16'h1111, 16'h0000, 1'h0, 16'h0000, 2'h0, 2'h2},
        '{5'h1F, 1'h0, 5'h1F, 5'h00, 16'h0000, 16'h4CE2, 1'h0, 16'h4CE2, 2'h0, 2'h1},
        '{5'h00, 1'h1, 5'h00, 5'h1F, 16'hFFFE, 16'h0000, 1'h0, 16'h0000, 2'h1, 2'h2},
        '{5'h13, 1'h0, 5'h13, 5'h11, 16'h0000, 16'hFFFF, 1'h1, 16'h7800, 2'h0, 2'h2},
        '{5'h13, 1'h0, 5'h13, 5'h02, 16'h0000, 16'h1234, 1'h1, 16'hFFFF, 2'h0, 2'h2},
        '{5'h13, 1'h1, 5'h13, 5'h11, 16'h6000, 16'h0000, 1'h1, 16'h0000, 2'h1, 2'h2},
        '{5'h13, 1'h1, 5'h13, 5'h11, 16'h0800, 16'h0000, 1'h1, 16'h0000, 2'h0, 2'h2},
        '{5'h13, 1'h1, 5'h13, 5'h05, 16'h6000, 16'h0000, 1'h1, 16'h0000, 2'h0, 2'h2}};
    logic        mclk_in, srst_in, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic        sleep, rd_req, wr_strobe, rd_req2, wr_strobe2;
    logic [4:0]  cmd_pa, cmd_ra, own_addr, reg_addr, reg_addr2;
    logic [15:0] cmd_wd, rsp_rdata, rd_data, wr_data, wr_data2;
    int          n_mismatch, tests_run, cyc, stb_n, req_n, stb2_n;

    mgmt_if link();
    mgmt_if bad_if();

    mgmt_host_master #(.MDC_HALF(HALF)) mgmt_host_master_inst (.mclk_in(mclk_in),
        .srst_in(srst_in), .bus(link.host), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
        .cmd_phy_addr_in(cmd_pa), .cmd_reg_addr_in(cmd_ra), .cmd_wdata_in(cmd_wd),
        .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata));
    mgmt_phy_slave mgmt_phy_slave_inst (.mclk_in(mclk_in), .srst_in(srst_in), .bus(link.phy),
        .own_bus_address_field_in(own_addr), .sleep_in(sleep), .rd_data_in(rd_data),
        .rd_req_out(rd_req), .reg_addr_out(reg_addr), .wr_data_out(wr_data),
        .wr_strobe_out(wr_strobe));
    // Second device faces the bench, which breaks the framing on purpose
    mgmt_phy_slave mgmt_phy_slave_inst2 (.mclk_in(mclk_in), .srst_in(srst_in),
        .bus(bad_if.phy), .own_bus_address_field_in(5'h07), .sleep_in(1'h0),
        .rd_data_in(16'h0000), .rd_req_out(rd_req2), .reg_addr_out(reg_addr2),
        .wr_data_out(wr_data2), .wr_strobe_out(wr_strobe2));
    mgmt_props #(.MDC_HALF(HALF)) chk_inst (.mclk_in(mclk_in), .srst_in(srst_in),
        .mdc(link.mdc), .mdio_host_out(link.mdio_host_out), .mdio_host_oe(link.mdio_host_oe),
        .mdio_phy_out(link.mdio_phy_out), .mdio_phy_oe(link.mdio_phy_oe), .mdio(link.mdio));

    initial begin
        mclk_in = 1'h0;
        forever #2.5 mclk_in = ~mclk_in;
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    // Ceiling sits well above the roughly 70000 cycles the sequence needs
    always @(posedge mclk_in) begin
        cyc++;
        if (wr_strobe === 1'h1) stb_n++;
        if (rd_req === 1'h1) req_n++;
        if (wr_strobe2 === 1'h1) stb2_n++;
        if (cyc == 90000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic issue(input row_t r);
        int i;
        own_addr = r.own;
        sleep = r.slp;
        rd_data = r.rd;
        stb_n = 0;
        req_n = 0;
        for (i = 0; i < 20 && cmd_ready !== 1'h1; i++) @(negedge mclk_in);
        cmd_valid = 1'h1;
        cmd_write = r.wr;
        cmd_pa = r.pa;
        cmd_ra = r.ra;
        cmd_wd = r.wd;
        @(negedge mclk_in);
        cmd_valid = 1'h0;
    endtask : issue

    task automatic run_row(input row_t r);
        int i;
        issue(r);
        for (i = 0; i < 6000 && rsp_valid !== 1'h1; i++) @(negedge mclk_in);
        chk16(16'(i), 16'(128 * HALF));
        if (r.wr) begin
            chk16(16'(stb_n), {14'h0000, r.stb});
            if (r.stb == 2'h1) begin
                chk16(wr_data, r.wd);
                chk16({11'h000, reg_addr}, {11'h000, r.ra});
            end
        end else begin
            chk16(rsp_rdata, r.exp);
            if (r.req != 2'h2) chk16(16'(req_n), {14'h0000, r.req});
        end
    endtask : run_row

    function automatic logic [63:0] mk(input logic [1:0] sof, input logic [1:0] op);
        mk = {mgmt_pkg::PREAMBLE_WORD, sof, op, 5'h07, 5'h03, mgmt_pkg::TA_WRITE, 16'h1234};
    endfunction : mk

    // Bench clock at 125 ns, stopped low between frames
    task automatic bang(input logic [63:0] f, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge mclk_in);
            bad_if.mdc = 1'h0;
            bad_if.mdio_host_oe = 1'h1;
            bad_if.mdio_host_out = f[63 - k];
            repeat (12) @(negedge mclk_in);
            bad_if.mdc = 1'h1;
            repeat (12) @(negedge mclk_in);
        end
        @(negedge mclk_in);
        bad_if.mdc = 1'h0;
        bad_if.mdio_host_oe = 1'h0;
        bad_if.mdio_host_out = 1'h1;
        repeat (10) @(negedge mclk_in);
    endtask : bang

    initial begin
        {srst_in, bad_if.mdio_host_out} = 2'h3;
        {cmd_valid, cmd_write, sleep, bad_if.mdc, bad_if.mdio_host_oe} = 5'h00;
        {cmd_pa, cmd_ra, own_addr, cmd_wd, rd_data} = 47'h0;
        repeat (20) @(negedge mclk_in);
        srst_in = 1'h0;
        foreach (rows[j]) run_row(rows[j]);
        stb2_n = 0;
        bang(mk(2'h1, 2'h1) << 1, 63);
        chk16(16'(stb2_n), 16'h0000);
        bang(mk(2'h0, 2'h1), 64);
        chk16(16'(stb2_n), 16'h0000);
        bang(mk(2'h1, 2'h3), 64);
        chk16(16'(stb2_n), 16'h0000);
        bang(mk(2'h1, 2'h1), 64);
        chk16(16'(stb2_n), 16'h0001);
        chk16(wr_data2, 16'h1234);
        chk16({11'h000, reg_addr2}, 16'h0003);
        // Reset in mid-frame must leave the line released and the host ready
        issue(rows[1]);
        repeat (3000) @(negedge mclk_in);
        srst_in = 1'h1;
        repeat (20) @(negedge mclk_in);
        srst_in = 1'h0;
        repeat (2) @(negedge mclk_in);
        chk16({13'h0, link.mdc, link.mdio_host_oe, link.mdio_phy_oe}, 16'h0000);
        chk16({15'h0, cmd_ready}, 16'h0001);
        run_row(rows[1]);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
